// File: hdl/wmc_waveform_mode_config.sv
/*
  Waveform mode configuration register with the logic it steers: waveform source
  selection, the waveform update strobe and routing of line energy into accumulators.
  Assumes register accesses arrive already decoded from the serial port as one-cycle
  strobes with address and data, synchronous to sys_clk, which is the master input clock.
*/
`default_nettype none

// Notes on behaviour
// - Waveform mode register at offset 0Ch; software writes it to set sampling.
// - Bits 0-2 pick voltage A/B/C or current A/B/C as sample source; reset 0.
// - Bits 3-4 set update rate to clock/3/128, 256, 512 or 1024; reset 0.
// - Bit 5 routes reactive energy to active, active energy to apparent accumulator.

module wmc_waveform_mode_config
  import wmc_pkg::*;
(
  input  wire logic                                  sys_clk,
  input  wire logic                                  reset,
  input  wire logic [wmc_pkg::ADDR_WIDTH-1:0]        reg_addr,
  input  wire logic                                  reg_write_strobe,
  input  wire logic [wmc_pkg::DATA_WIDTH-1:0]        reg_write_data,
  input  wire logic                                  reg_read_strobe,
  output logic      [wmc_pkg::DATA_WIDTH-1:0]        reg_read_data,
  output logic                                       reg_read_valid,
  input  wire logic signed [wmc_pkg::SAMPLE_WIDTH-1:0] voltage_a,
  input  wire logic signed [wmc_pkg::SAMPLE_WIDTH-1:0] voltage_b,
  input  wire logic signed [wmc_pkg::SAMPLE_WIDTH-1:0] voltage_c,
  input  wire logic signed [wmc_pkg::SAMPLE_WIDTH-1:0] current_a,
  input  wire logic signed [wmc_pkg::SAMPLE_WIDTH-1:0] current_b,
  input  wire logic signed [wmc_pkg::SAMPLE_WIDTH-1:0] current_c,
  output logic signed      [wmc_pkg::SAMPLE_WIDTH-1:0] waveform_sample,
  output logic                                       waveform_sample_valid,
  input  wire logic signed [wmc_pkg::ENERGY_WIDTH-1:0] line_active_energy,
  input  wire logic signed [wmc_pkg::ENERGY_WIDTH-1:0] line_reactive_energy,
  input  wire logic signed [wmc_pkg::ENERGY_WIDTH-1:0] line_apparent_energy,
  output logic signed      [wmc_pkg::ENERGY_WIDTH-1:0] line_active_accumulator_add,
  output logic signed      [wmc_pkg::ENERGY_WIDTH-1:0] line_apparent_accumulator_add,
  output logic      [2:0]                            sample_source_select,
  output logic      [1:0]                            sample_rate_select,
  output logic                                       line_reactive_redirect
);

  import wmc_pkg::*;

  function automatic logic signed [SAMPLE_WIDTH-1:0] pick_source(
    input logic [2:0]                      source,
    input logic signed [SAMPLE_WIDTH-1:0]  va,
    input logic signed [SAMPLE_WIDTH-1:0]  vb,
    input logic signed [SAMPLE_WIDTH-1:0]  vc,
    input logic signed [SAMPLE_WIDTH-1:0]  ia,
    input logic signed [SAMPLE_WIDTH-1:0]  ib,
    input logic signed [SAMPLE_WIDTH-1:0]  ic
  );
    logic signed [SAMPLE_WIDTH-1:0] value;
    value = '0;
    unique case (source)
      SOURCE_VOLTAGE_A: value = va;
      SOURCE_VOLTAGE_B: value = vb;
      SOURCE_VOLTAGE_C: value = vc;
      SOURCE_CURRENT_A: value = ia;
      SOURCE_CURRENT_B: value = ib;
      SOURCE_CURRENT_C: value = ic;
      default:          value = '0;
    endcase
    return value;
  endfunction : pick_source

  logic       config_hit;
  logic       source_legal;
  logic       sample_tick;
  logic [2:0] next_source;

  assign config_hit   = (reg_addr == WAVEFORM_MODE_CONFIG_OFFSET);
  assign next_source  = reg_write_data[SOURCE_MSB:SOURCE_LSB];
  assign source_legal = (next_source <= SOURCE_LAST_LEGAL);

  // The source field only takes legal codes; the other fields of the same write still land.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sample_source_select <= SOURCE_RESET;
    else if (reg_write_strobe && config_hit && source_legal)
      sample_source_select <= next_source;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sample_rate_select     <= RATE_RESET;
      line_reactive_redirect <= REDIRECT_RESET;
    end
    else if (reg_write_strobe && config_hit)
    begin
      sample_rate_select     <= reg_write_data[RATE_MSB:RATE_LSB];
      line_reactive_redirect <= reg_write_data[REDIRECT_BIT];
    end
  end

  // Reads return the contents before any write in the same cycle; reserved bits read zero.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_read_data  <= 8'h00;
      reg_read_valid <= 1'b0;
    end
    else
    begin
      reg_read_valid <= reg_read_strobe;
      if (reg_read_strobe && config_hit)
        reg_read_data <= {2'h0, line_reactive_redirect, sample_rate_select, sample_source_select};
      else if (reg_read_strobe)
        reg_read_data <= 8'h00;
    end
  end

  wmc_rate_divider u_rate_divider (
    .sys_clk            (sys_clk),
    .reset              (reset),
    .sample_rate_select (sample_rate_select),
    .sample_tick        (sample_tick)
  );

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      waveform_sample       <= '0;
      waveform_sample_valid <= 1'b0;
    end
    else
    begin
      waveform_sample_valid <= sample_tick;
      if (sample_tick)
        waveform_sample <= pick_source(sample_source_select, voltage_a, voltage_b, voltage_c,
                                       current_a, current_b, current_c);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      line_active_accumulator_add   <= '0;
      line_apparent_accumulator_add <= '0;
    end
    else if (line_reactive_redirect)
    begin
      line_active_accumulator_add   <= line_reactive_energy;
      line_apparent_accumulator_add <= line_active_energy;
    end
    else
    begin
      line_active_accumulator_add   <= line_active_energy;
      line_apparent_accumulator_add <= line_apparent_energy;
    end
  end

  a_config_write: assert property (
    @(posedge sys_clk) disable iff (reset)
    reg_write_strobe && config_hit
      |=> sample_rate_select == $past(reg_write_data[RATE_MSB:RATE_LSB])
          && line_reactive_redirect == $past(reg_write_data[REDIRECT_BIT]))
    else $error("Write to the waveform mode register did not update rate and redirect.");

  a_config_readback: assert property (
    @(posedge sys_clk) disable iff (reset)
    reg_read_strobe && config_hit && !reg_write_strobe
      ##1 !reg_write_strobe && !reg_read_strobe
      |=> reg_read_valid == 1'b0
          && reg_read_data == {2'h0, line_reactive_redirect, sample_rate_select, sample_source_select})
    else $error("Read data does not reflect the waveform mode register.");

  a_source_legal_write: assert property (
    @(posedge sys_clk) disable iff (reset)
    reg_write_strobe && config_hit && source_legal |=> sample_source_select == $past(next_source))
    else $error("Legal source code was not stored.");

  a_reserved_ignored: assert property (
    @(posedge sys_clk) disable iff (reset)
    reg_write_strobe && config_hit && !source_legal |=> $stable(sample_source_select))
    else $error("Reserved source code changed the selected source.");

  a_sample_source: assert property (
    @(posedge sys_clk) disable iff (reset)
    sample_tick |=> waveform_sample_valid
      && waveform_sample == pick_source($past(sample_source_select), $past(voltage_a), $past(voltage_b),
                                        $past(voltage_c), $past(current_a), $past(current_b), $past(current_c)))
    else $error("Waveform sample does not come from the selected source.");

  a_sample_hold: assert property (
    @(posedge sys_clk) disable iff (reset)
    !sample_tick |=> !waveform_sample_valid && $stable(waveform_sample))
    else $error("Waveform sample changed without an update strobe.");

  a_energy_route: assert property (
    @(posedge sys_clk) disable iff (reset)
    1'b1 |=> line_active_accumulator_add ==
               ($past(line_reactive_redirect) ? $past(line_reactive_energy) : $past(line_active_energy))
             && line_apparent_accumulator_add ==
               ($past(line_reactive_redirect) ? $past(line_active_energy) : $past(line_apparent_energy)))
    else $error("Line energy was routed to the wrong accumulator.");

  a_reserved_never: assert property (
    @(posedge sys_clk) disable iff (reset)
    sample_source_select <= SOURCE_LAST_LEGAL)
    else $error("Selected source holds a reserved code.");

  c_config_write: cover property (
    @(posedge sys_clk) disable iff (reset)
    reg_write_strobe && config_hit && source_legal ##1 reg_read_strobe && config_hit);

  c_reserved_write: cover property (
    @(posedge sys_clk) disable iff (reset)
    reg_write_strobe && config_hit && !source_legal);

  c_redirect_sample: cover property (
    @(posedge sys_clk) disable iff (reset)
    line_reactive_redirect && sample_tick && sample_source_select == SOURCE_CURRENT_C);

endmodule : wmc_waveform_mode_config

`default_nettype wire

// File: hdl/wmc_pkg.sv
/*
  Shared constants for the waveform mode configuration block: the register offset,
  field positions, values after reset, source codes and the sample rate divisors.
  Assumes nothing beyond a SystemVerilog compiler that accepts packages.
*/
`default_nettype none

package wmc_pkg;

  localparam int unsigned ADDR_WIDTH   = 6;
  localparam int unsigned DATA_WIDTH   = 8;
  localparam int unsigned SAMPLE_WIDTH = 24;
  localparam int unsigned ENERGY_WIDTH = 16;

  localparam logic [ADDR_WIDTH-1:0] WAVEFORM_MODE_CONFIG_OFFSET = 6'h0C;

  localparam int unsigned SOURCE_LSB   = 0;
  localparam int unsigned SOURCE_MSB   = 2;
  localparam int unsigned RATE_LSB     = 3;
  localparam int unsigned RATE_MSB     = 4;
  localparam int unsigned REDIRECT_BIT = 5;

  localparam logic [2:0] SOURCE_RESET   = 3'h0;
  localparam logic [1:0] RATE_RESET     = 2'h0;
  localparam logic       REDIRECT_RESET = 1'b0;

  localparam logic [2:0] SOURCE_VOLTAGE_A = 3'h0;
  localparam logic [2:0] SOURCE_VOLTAGE_B = 3'h1;
  localparam logic [2:0] SOURCE_VOLTAGE_C = 3'h2;
  localparam logic [2:0] SOURCE_CURRENT_A = 3'h3;
  localparam logic [2:0] SOURCE_CURRENT_B = 3'h4;
  localparam logic [2:0] SOURCE_CURRENT_C = 3'h5;
  localparam logic [2:0] SOURCE_LAST_LEGAL = SOURCE_CURRENT_C;

  localparam logic [1:0] PRESCALE_LAST = 2'h2;
  localparam logic [9:0] RATE_LAST_128  = 10'h07F;
  localparam logic [9:0] RATE_LAST_256  = 10'h0FF;
  localparam logic [9:0] RATE_LAST_512  = 10'h1FF;
  localparam logic [9:0] RATE_LAST_1024 = 10'h3FF;

  function automatic logic [9:0] wmc_rate_last(input logic [1:0] rate);
    logic [9:0] last;
    last = RATE_LAST_128;
    unique case (rate)
      2'h0: last = RATE_LAST_128;
      2'h1: last = RATE_LAST_256;
      2'h2: last = RATE_LAST_512;
      2'h3: last = RATE_LAST_1024;
    endcase
    return last;
  endfunction : wmc_rate_last

  function automatic logic [12:0] wmc_tick_period(input logic [1:0] rate);
    logic [12:0] n;
    n = {3'h0, wmc_rate_last(rate)} + 13'h0001;
    return 13'((n << 1) + n);
  endfunction : wmc_tick_period

endpackage : wmc_pkg

`default_nettype wire

// File: hdl/wmc_rate_divider.sv
/*
  Waveform update strobe generator: divides the system clock by three and then by
  128, 256, 512 or 1024 according to the rate select code.
  Assumes the rate code comes from a flip-flop in the same clock domain.
*/
`default_nettype none

module wmc_rate_divider
  import wmc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [1:0] sample_rate_select,
  output logic            sample_tick
);

  logic [1:0] prescale_count;
  logic [9:0] rate_count;
  logic [9:0] rate_last;

  assign rate_last = wmc_rate_last(sample_rate_select);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      prescale_count <= 2'h0;
    else if (prescale_count == PRESCALE_LAST)
      prescale_count <= 2'h0;
    else
      prescale_count <= prescale_count + 2'h1;
  end

  // A rate change that leaves the count above the new limit wraps at the next prescale step.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rate_count <= 10'h000;
    else if (prescale_count == PRESCALE_LAST)
    begin
      if (rate_count >= rate_last)
        rate_count <= 10'h000;
      else
        rate_count <= rate_count + 10'h001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sample_tick <= 1'b0;
    else
      sample_tick <= (prescale_count == PRESCALE_LAST) && (rate_count >= rate_last);
  end

  logic [12:0] gap_count;
  logic        gap_valid;
  logic        rate_changed;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      gap_count    <= 13'h0000;
      gap_valid    <= 1'b0;
      rate_changed <= 1'b0;
    end
    else
    begin
      gap_count    <= sample_tick ? 13'h0001 : gap_count + 13'h0001;
      gap_valid    <= gap_valid | sample_tick;
      rate_changed <= sample_tick ? 1'b0 : (rate_changed | (sample_rate_select != $past(sample_rate_select)));
    end
  end

  a_tick_period: assert property (
    @(posedge sys_clk) disable iff (reset)
    sample_tick && gap_valid && !rate_changed && $stable(sample_rate_select)
      |-> gap_count == wmc_tick_period(sample_rate_select))
    else $error("Waveform update strobe period does not match the rate code.");

  a_tick_single: assert property (
    @(posedge sys_clk) disable iff (reset)
    sample_tick |=> !sample_tick [*2])
    else $error("Waveform update strobe came closer than the prescale allows.");

  c_tick_slowest: cover property (
    @(posedge sys_clk) disable iff (reset)
    sample_tick && gap_valid && sample_rate_select == 2'h3);

endmodule : wmc_rate_divider

`default_nettype wire

// File: test/tb_top.sv
/*
  Self-checking bench for the waveform mode configuration block: register access,
  source selection, update rate, reserved codes and energy redirection.
  Assumes the design package and module are compiled first; inputs change on falling edges.
*/
`default_nettype none

module tb_top
  import wmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     sys_clk          = 1'b0;
  logic                     reset            = 1'b1;
  logic [ADDR_WIDTH-1:0]    reg_addr         = 6'h00;
  logic                     reg_write_strobe = 1'b0;
  logic [DATA_WIDTH-1:0]    reg_write_data   = 8'h00;
  logic                     reg_read_strobe  = 1'b0;
  logic [DATA_WIDTH-1:0]    reg_read_data;
  logic                     reg_read_valid;
  logic signed [23:0]       voltage_a = 24'h0A0001;
  logic signed [23:0]       voltage_b = 24'h0B0002;
  logic signed [23:0]       voltage_c = 24'h0C0003;
  logic signed [23:0]       current_a = 24'h1A0004;
  logic signed [23:0]       current_b = 24'h1B0005;
  logic signed [23:0]       current_c = 24'h1C0006;
  logic signed [23:0]       waveform_sample;
  logic                     waveform_sample_valid;
  logic signed [15:0]       line_active_energy   = 16'h1111;
  logic signed [15:0]       line_reactive_energy = 16'h2222;
  logic signed [15:0]       line_apparent_energy = 16'h3333;
  logic signed [15:0]       active_add;
  logic signed [15:0]       apparent_add;
  logic [2:0]               sample_source_select;
  logic [1:0]               sample_rate_select;
  logic                     line_reactive_redirect;
  int                       err_total = 0;
  int                       n_tests   = 0;
  logic [23:0]              exp_smp[6] = '{24'h0A0001, 24'h0B0002, 24'h0C0003, 24'h1A0004, 24'h1B0005, 24'h1C0006};

  always #2 sys_clk = ~sys_clk;

  wmc_waveform_mode_config i_dut (
    .sys_clk                       (sys_clk),
    .reset                         (reset),
    .reg_addr                      (reg_addr),
    .reg_write_strobe              (reg_write_strobe),
    .reg_write_data                (reg_write_data),
    .reg_read_strobe               (reg_read_strobe),
    .reg_read_data                 (reg_read_data),
    .reg_read_valid                (reg_read_valid),
    .voltage_a                     (voltage_a),
    .voltage_b                     (voltage_b),
    .voltage_c                     (voltage_c),
    .current_a                     (current_a),
    .current_b                     (current_b),
    .current_c                     (current_c),
    .waveform_sample               (waveform_sample),
    .waveform_sample_valid         (waveform_sample_valid),
    .line_active_energy            (line_active_energy),
    .line_reactive_energy          (line_reactive_energy),
    .line_apparent_energy          (line_apparent_energy),
    .line_active_accumulator_add   (active_add),
    .line_apparent_accumulator_add (apparent_add),
    .sample_source_select          (sample_source_select),
    .sample_rate_select            (sample_rate_select),
    .line_reactive_redirect        (line_reactive_redirect)
  );

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask : chk

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr         = a;
    reg_write_data   = d;
    reg_write_strobe = 1'b1;
    @(negedge sys_clk);
    reg_write_strobe = 1'b0;
    @(negedge sys_clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    int i;
    @(negedge sys_clk);
    reg_addr        = a;
    reg_read_strobe = 1'b1;
    @(negedge sys_clk);
    reg_read_strobe = 1'b0;
    for (i = 0; i < 4 && reg_read_valid !== 1'b1; i++) @(negedge sys_clk);
    chk("read valid", reg_read_valid, 24'h1);
    if (reg_read_valid !== 1'b1)
      end_sim();
    d = reg_read_data;
  endtask : rd_reg

  // Counts falling edges until the next sample strobe.
  task automatic wait_valid(output int n);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (waveform_sample_valid !== 1'b1 && n < 5000);
    chk("sample valid", waveform_sample_valid, 24'h1);
    if (waveform_sample_valid !== 1'b1)
      end_sim();
  endtask : wait_valid

  task automatic test_reset_and_map;
    logic [7:0] d;
    rd_reg(WAVEFORM_MODE_CONFIG_OFFSET, d);
    chk("reset value", d, 24'h0);
    chk("reset fields", {line_reactive_redirect, sample_rate_select, sample_source_select}, 24'h0);
    wr_reg(6'h0D, 8'h3F);
    rd_reg(WAVEFORM_MODE_CONFIG_OFFSET, d);
    chk("other address write", d, 24'h0);
    rd_reg(6'h0D, d);
    chk("other address read", d, 24'h0);
    $display("test reset_and_map done");
  endtask : test_reset_and_map

  task automatic test_source;
    logic [7:0] d;
    int         n;
    for (int s = 0; s < 6; s++)
    begin
      wr_reg(WAVEFORM_MODE_CONFIG_OFFSET, 8'(s));
      rd_reg(WAVEFORM_MODE_CONFIG_OFFSET, d);
      chk("source readback", d, 24'(s));
      wait_valid(n);
      wait_valid(n);
      chk("waveform sample", waveform_sample, exp_smp[s]);
    end
    $display("test source done");
  endtask : test_source

  task automatic test_reserved;
    logic [7:0] d;
    int         n;
    wr_reg(WAVEFORM_MODE_CONFIG_OFFSET, 8'h04);
    wr_reg(WAVEFORM_MODE_CONFIG_OFFSET, 8'h2E);
    rd_reg(WAVEFORM_MODE_CONFIG_OFFSET, d);
    chk("reserved code 6", d, 24'h2C);
    wr_reg(WAVEFORM_MODE_CONFIG_OFFSET, 8'hC7);
    rd_reg(WAVEFORM_MODE_CONFIG_OFFSET, d);
    chk("reserved code 7", d, 24'h04);
    wait_valid(n);
    wait_valid(n);
    chk("sample after reserved", waveform_sample, exp_smp[4]);
    $display("test reserved done");
  endtask : test_reserved

  task automatic test_rate;
    int n;
    for (int r = 0; r < 4; r++)
    begin
      wr_reg(WAVEFORM_MODE_CONFIG_OFFSET, 8'(r << 3));
      chk("rate field", sample_rate_select, 24'(r));
      wait_valid(n);
      wait_valid(n);
      chk("update period", 24'(n), 24'(3 * (128 << r)));
    end
    $display("test rate done");
  endtask : test_rate

  task automatic test_redirect;
    for (int x = 0; x < 2; x++)
    begin
      wr_reg(WAVEFORM_MODE_CONFIG_OFFSET, 8'(x << 5));
      @(negedge sys_clk);
      chk("redirect bit", line_reactive_redirect, 24'(x));
      chk("active add", active_add, (x == 1) ? 24'h2222 : 24'h1111);
      chk("apparent add", apparent_add, (x == 1) ? 24'h1111 : 24'h3333);
    end
    line_active_energy = 16'h0456;
    @(negedge sys_clk);
    @(negedge sys_clk);
    chk("apparent add follows", apparent_add, 24'h0456);
    $display("test redirect done");
  endtask : test_redirect

  // Resets in mid-run with every field set, then times the first update after release.
  task automatic test_reset_mid;
    int n;
    wr_reg(WAVEFORM_MODE_CONFIG_OFFSET, 8'h2D);
    wait_valid(n);
    reset = 1'b1;
    @(negedge sys_clk);
    chk("fields in reset", {line_reactive_redirect, sample_rate_select, sample_source_select}, 24'h0);
    chk("sample in reset", waveform_sample, 24'h0);
    chk("sample valid in reset", waveform_sample_valid, 24'h0);
    chk("read data in reset", reg_read_data, 24'h0);
    chk("active add in reset", active_add, 24'h0);
    chk("apparent add in reset", apparent_add, 24'h0);
    reset = 1'b0;
    wait_valid(n);
    chk("first update after reset", 24'(n), 24'(3 * 128 + 1));
    chk("sample after reset", waveform_sample, exp_smp[0]);
    $display("test reset_mid done");
  endtask : test_reset_mid

  initial
  begin
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    test_reset_and_map();
    test_source();
    test_reserved();
    test_rate();
    test_redirect();
    test_reset_mid();
    end_sim();
  end

endmodule : tb_top

`default_nettype wire
